// ==== core/fbw_host.sv ====
// Host controller driving the asynchronous byte/word flash bus port
`timescale 1ns/100ps
`default_nettype none
`include "fbw_map.svh"
module fbw_host #(
  parameter int SETUP_CYC = `FBW_SETUP_CYC,
  parameter int STROBE_CYC = `FBW_STROBE_CYC,
  parameter int HOLD_CYC = `FBW_HOLD_CYC,
  parameter int RESET_CYC = `FBW_RESET_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_byte_mode,
  input wire logic [`FBW_BYTE_ADDR_W-1:0] req_addr,
  input wire logic [`FBW_DATA_W-1:0] req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [`FBW_DATA_W-1:0] rsp_rdata,
  // Flash control pins
  output logic chip_sel_n,
  output logic out_en_n,
  output logic write_en_n,
  output logic byte_sel_n,
  output logic reset_powerdown_n,
  output logic [`FBW_ADDR_W-1:0] address_inputs,
  // Flash data pins
  input wire logic [`FBW_DATA_W-1:0] data_in,
  output logic [`FBW_DATA_W-1:0] data_out,
  output logic [`FBW_DATA_W-1:0] data_oe
);
  import fbw_pkg::*;

  initial begin
    // The strobe must outlast the two-flop data synchroniser by one cycle
    if (SETUP_CYC < 1 || STROBE_CYC < 3 || HOLD_CYC < 1 || RESET_CYC < 1 ||
        STROBE_CYC > 255 || SETUP_CYC > 255 || HOLD_CYC > 255 || RESET_CYC > 255) begin
      $error("fbw_host: timing counts out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser
  logic [`FBW_DATA_W-1:0] din_s1_q, din_s2_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  fbw_state_type state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic byte_q, byte_d;
  logic bsel_n_q, bsel_n_d;
  logic cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, rp_n_q, rp_n_d;
  logic ready_q, ready_d, rvalid_q, rvalid_d;
  logic [`FBW_ADDR_W-1:0] addr_q, addr_d;
  logic [`FBW_DATA_W-1:0] dout_q, dout_d, doe_q, doe_d, rdata_q, rdata_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    byte_d = byte_q;
    bsel_n_d = bsel_n_q;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    rp_n_d = rp_n_q;
    ready_d = 1'b0;
    rvalid_d = 1'b0;
    addr_d = addr_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rdata_d = rdata_q;
    case (state_q)
      FBW_RESET: begin
        // Hold the device in reset/power-down with all pins quiet
        rp_n_d = 1'b0;
        if (cnt_q == 8'(RESET_CYC - 1)) begin
          rp_n_d = 1'b1;
          cnt_d = 8'h00;
          ready_d = 1'b1;
          state_d = FBW_IDLE;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      FBW_IDLE: begin
        ready_d = 1'b1;
        if (req_valid && ready_q) begin
          ready_d = 1'b0;
          wr_d = req_write;
          byte_d = req_byte_mode;
          bsel_n_d = ~req_byte_mode;
          cs_n_d = 1'b0;
          addr_d = req_byte_mode ? req_addr[`FBW_BYTE_ADDR_W-1:1]
                                 : req_addr[`FBW_ADDR_W-1:0];
          dout_d = 16'h0000;
          doe_d = 16'h0000;
          if (req_byte_mode) begin
            dout_d[15] = req_addr[0];
            doe_d[15] = 1'b1;
            if (req_write) begin
              // Commands and byte data use only the low lines
              dout_d[7:0] = req_wdata[7:0];
              doe_d[7:0] = 8'hFF;
            end
          end else if (req_write) begin
            dout_d = req_wdata;
            doe_d = 16'hFFFF;
          end
          cnt_d = 8'h00;
          state_d = FBW_SETUP;
        end
      end
      FBW_SETUP: begin
        if (cnt_q == 8'(SETUP_CYC - 1)) begin
          cnt_d = 8'h00;
          if (wr_q) begin
            we_n_d = 1'b0;
          end else begin
            oe_n_d = 1'b0;
          end
          state_d = FBW_STROBE;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      FBW_STROBE: begin
        if (cnt_q == 8'(STROBE_CYC - 1)) begin
          cnt_d = 8'h00;
          we_n_d = 1'b1;
          oe_n_d = 1'b1;
          if (!wr_q) begin
            rvalid_d = 1'b1;
            // Byte reads return only the low lines
            rdata_d = byte_q ? {8'h00, din_s2_q[7:0]} : din_s2_q;
          end
          state_d = FBW_HOLD;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      FBW_HOLD: begin
        if (cnt_q == 8'(HOLD_CYC - 1)) begin
          cnt_d = 8'h00;
          cs_n_d = 1'b1;
          doe_d = 16'h0000;
          ready_d = 1'b1;
          state_d = FBW_IDLE;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default: begin
        state_d = FBW_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= FBW_RESET;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      byte_q <= 1'b0;
      bsel_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rp_n_q <= 1'b0;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      addr_q <= 17'h00000;
      dout_q <= 16'h0000;
      doe_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      byte_q <= byte_d;
      bsel_n_q <= bsel_n_d;
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rp_n_q <= rp_n_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rdata_q <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = ready_q;
  assign rsp_valid = rvalid_q;
  assign rsp_rdata = rdata_q;
  assign chip_sel_n = cs_n_q;
  assign out_en_n = oe_n_q;
  assign write_en_n = we_n_q;
  assign byte_sel_n = bsel_n_q;
  assign reset_powerdown_n = rp_n_q;
  assign address_inputs = addr_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
endmodule
`default_nettype wire

// ==== core/fbw_map.svh ====
// Constants for the flash byte/word bus port host controller
`ifndef FBW_MAP_SVH
`define FBW_MAP_SVH
`define FBW_ADDR_W 17
`define FBW_BYTE_ADDR_W 18
`define FBW_DATA_W 16
`define FBW_SETUP_NS 20
`define FBW_STROBE_NS 80
`define FBW_HOLD_NS 20
`define FBW_CLK_NS 4
`define FBW_SETUP_CYC ((`FBW_SETUP_NS + `FBW_CLK_NS - 1) / `FBW_CLK_NS)
`define FBW_STROBE_CYC ((`FBW_STROBE_NS + `FBW_CLK_NS - 1) / `FBW_CLK_NS)
`define FBW_HOLD_CYC ((`FBW_HOLD_NS + `FBW_CLK_NS - 1) / `FBW_CLK_NS)
`define FBW_RESET_CYC 8
`define FBW_CMD_READ_ARRAY 8'hFF
`endif

// ==== core/fbw_pkg.sv ====
// Types for the flash byte/word bus port host controller
`default_nettype none
package fbw_pkg;
  typedef enum logic [2:0] {
    FBW_RESET,
    FBW_IDLE,
    FBW_SETUP,
    FBW_STROBE,
    FBW_HOLD
  } fbw_state_type;
endpackage
`default_nettype wire

// ==== verif/fbw_flash_model.sv ====
// Behavioural flash device on the far side of the host controller
`timescale 1ns/100ps
`default_nettype none
module fbw_flash_model (
  input wire logic chip_sel_n, out_en_n, write_en_n, byte_sel_n, reset_powerdown_n,
  input wire logic [16:0] address_inputs,
  input wire logic [15:0] bus,
  output logic [15:0] dev_out, dev_oe
);
  logic [7:0] mem [32];
  logic [4:0] lo, hi;
  assign lo = {address_inputs[3:0], byte_sel_n ? 1'b0 : bus[15]};
  assign hi = {address_inputs[3:0], 1'b1};
  assign dev_out = byte_sel_n ? {mem[hi], mem[lo]} : {8'h00, mem[lo]};
  assign dev_oe = (reset_powerdown_n && !chip_sel_n && !out_en_n) ?
    (byte_sel_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge write_en_n) if (reset_powerdown_n && !chip_sel_n) begin
    mem[lo] <= bus[7:0];
    if (byte_sel_n) mem[hi] <= bus[15:8];
  end
endmodule
`default_nettype wire

// ==== verif/fbw_host_sva.sv ====
// Checker for the flash bus port host controller
`timescale 1ns/100ps
`default_nettype none
`include "fbw_map.svh"
module fbw_host_sva #(parameter int STROBE_CYC = 4) (
  input wire logic clk, reset_n, req_valid, req_ready, rsp_valid,
  input wire logic chip_sel_n, out_en_n, write_en_n, byte_sel_n, reset_powerdown_n,
  input wire logic [`FBW_BYTE_ADDR_W-1:0] req_addr,
  input wire logic [`FBW_ADDR_W-1:0] address_inputs,
  input wire logic [`FBW_DATA_W-1:0] data_out, data_oe
);
  logic [17:0] addr_q;
  always_ff @(posedge clk) if (req_valid && req_ready) addr_q <= req_addr;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_we_end; $rose(write_en_n); endsequence
  sequence s_oe_end; $rose(out_en_n); endsequence
  a_oe_len: assert property ($fell(out_en_n) |-> ##STROBE_CYC s_oe_end)
    else $error("read strobe length");
  a_byte_addr: assert property (!out_en_n && !byte_sel_n |-> data_oe[15])
    else $error("low address line not driven in byte read");
  a_read_release: assert property (!out_en_n |-> data_oe[14:0] == 15'h0000)
    else $error("host drives bus in read");
  a_word_top: assert property (!out_en_n && byte_sel_n |-> !data_oe[15])
    else $error("top line driven in word read");
  a_write_drive: assert property (!write_en_n |-> out_en_n &&
    data_oe == (byte_sel_n ? 16'hFFFF : 16'h80FF)) else $error("bad write drive");
  a_we_len: assert property ($fell(write_en_n) |-> ##STROBE_CYC s_we_end)
    else $error("write strobe length");
  a_read_answer: assert property ($rose(out_en_n) |-> rsp_valid)
    else $error("no read answer");
  a_sel_frame: assert property (!out_en_n || !write_en_n |-> !chip_sel_n)
    else $error("strobe without select");
  a_pd_quiet: assert property (!reset_powerdown_n |-> chip_sel_n && data_oe == 16'h0000)
    else $error("bus active in power down");
  a_take_addr: assert property (s_take |=> (byte_sel_n ? address_inputs == addr_q[16:0] :
    address_inputs == addr_q[17:1] && data_out[15] == addr_q[0])) else $error("bad address");
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the flash bus port host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_byte_mode = 0, tog = 0;
  logic req_ready, rsp_valid, chip_sel_n, out_en_n, write_en_n, byte_sel_n, reset_powerdown_n;
  logic [17:0] req_addr = 0;
  logic [16:0] address_inputs;
  logic [15:0] req_wdata = 0, rsp_rdata, data_out, data_oe, dev_out, dev_oe, bus;
  logic [15:0] r = 16'h004A;
  logic [7:0] exp_mem [32];
  int errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  always @(posedge clk) tog <= ~tog;
  // Undriven lines wander so a stale value is never mistaken for data
  assign bus = (data_oe & data_out) | (~data_oe & dev_oe & dev_out) |
    (~data_oe & ~dev_oe & {16{tog}});
  fbw_host #(.SETUP_CYC(1), .STROBE_CYC(4), .HOLD_CYC(1), .RESET_CYC(2)) dut (.clk(clk),
    .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
    .req_byte_mode(req_byte_mode), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .byte_sel_n(byte_sel_n), .reset_powerdown_n(reset_powerdown_n),
    .address_inputs(address_inputs), .data_in(bus), .data_out(data_out), .data_oe(data_oe));
  fbw_flash_model u_flash (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .byte_sel_n(byte_sel_n), .reset_powerdown_n(reset_powerdown_n),
    .address_inputs(address_inputs), .bus(bus), .dev_out(dev_out), .dev_oe(dev_oe));
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] exp_rd(input logic bm, input logic [17:0] a);
    return bm ? {8'h00, exp_mem[a[4:0]]} : {exp_mem[{a[3:0], 1'b1}], exp_mem[{a[3:0], 1'b0}]};
  endfunction
  task automatic op(input logic w, bm, input logic [17:0] a, input logic [15:0] d);
    int k;
    for (k = 0; k < 60 && req_ready !== 1'b1; k++) @(posedge clk);
    `CHK(req_ready, 1'b1)
    req_valid <= 1'b1;
    req_write <= w;
    req_byte_mode <= bm;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    if (w && bm) exp_mem[a[4:0]] = d[7:0];
    if (w && !bm) {exp_mem[{a[3:0], 1'b1}], exp_mem[{a[3:0], 1'b0}]} = d;
    if (!w) begin
      for (k = 0; k < 60 && rsp_valid !== 1'b1; k++) @(posedge clk);
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_rdata, exp_rd(bm, a))
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    foreach (exp_mem[i]) exp_mem[i] = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    op(1'b1, 1'b1, 18'h00001, 16'h00A5);
    op(1'b1, 1'b1, 18'h00002, 16'h00FF);
    op(1'b0, 1'b0, 18'h00000, 16'h0000);
    op(1'b0, 1'b1, 18'h3FFFF, 16'h0000);
    $display("test corner done");
    for (int i = 0; i < 60; i++) begin
      r = lf(r);
      op(r[0], r[1], {r[15:2], r[3:0]}, lf(r));
    end
    $display("test random done");
    complete_run();
  end
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule
bind fbw_host fbw_host_sva #(.STROBE_CYC(STROBE_CYC)) u_sva (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
  .byte_sel_n(byte_sel_n), .reset_powerdown_n(reset_powerdown_n), .req_addr(req_addr),
  .address_inputs(address_inputs), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire
